/* File: hdl/fdtp_pkg.sv */
// Constants and types of the frame delimiter timestamp pulse block
package fdtp_pkg;

  // Register bus geometry; byte address is four times the index
  localparam int AXI_AW = 12;
  localparam int IDX_W = 9;
  localparam logic [IDX_W-1:0] IDX_PHY_CONTROL = 9'h01F;
  localparam logic [IDX_W-1:0] IDX_SKEW_STATUS = 9'h055;
  localparam logic [IDX_W-1:0] IDX_ALIGN_CTRL = 9'h0E9;
  localparam logic [IDX_W-1:0] IDX_RX_FEATURE = 9'h134;
  localparam logic [IDX_W-1:0] IDX_PIN_ROUTE = 9'h1E0;
  localparam logic [IDX_W-1:0] IDX_PULSE_PHASE = 9'h1E1;

  // Field positions
  localparam int SOFT_RESTART_BIT = 14;
  localparam int MAC_EXTRAS_BIT = 7;
  localparam int RX_SEL_LSB = 0;
  localparam int RX_ROUTE_EN_BIT = 3;
  localparam int TX_SEL_LSB = 4;
  localparam int TX_ROUTE_EN_BIT = 7;
  localparam int SEL_W = 2;
  localparam int RX_PHASE_LSB = 0;
  localparam int TX_PHASE_LSB = 8;
  localparam int MASTER_SKEW_LSB = 4;
  localparam int SLAVE_SKEW_LSB = 0;
  localparam int NUM_PINS = 4;

  // Reset values
  localparam logic [15:0] PHY_CONTROL_RST = 16'h0000;
  localparam logic [15:0] ALIGN_CTRL_RST = 16'h0000;
  localparam logic [15:0] RX_FEATURE_RST = 16'h0000;
  localparam logic [15:0] PIN_ROUTE_RST = 16'h0000;
  localparam logic [15:0] PULSE_PHASE_RST = 16'h0000;

  // Alignment FIFO value that arms skew reporting
  localparam logic [15:0] ALIGN_INIT_VALUE = 16'hDF22;

  // Timing: one phase or skew count is one step
  localparam int CLK_NS = 8;
  localparam int STEP_NS = 8;
  localparam int STEP_CYCLES = (STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] SKEW_LIMIT = 4'hF;
  localparam int DELAY_DEPTH = 32;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [AXI_AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AXI_AW-1:0] araddr;
    logic rready;
  } fdtp_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } fdtp_axil_rsp_t;

  // Status of the PHY core, same clock
  typedef struct packed {
    logic link_up;
    logic speed_1000;
    logic master;
  } fdtp_phy_stat_t;

  // Arrival offset of each of the four pairs, in clock cycles
  typedef logic [3:0][5:0] fdtp_lane_off_t;

endpackage

/* File: hdl/fdtp_pulse_delay.sv */
// Programmable delay line for a one-cycle strobe
`timescale 1ns/1ns
`default_nettype none
module fdtp_pulse_delay (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Strobe in, delayed pulse out
  input wire logic strobe,
  input wire logic [4:0] delay,
  output logic pulse
);
  import fdtp_pkg::*;

  logic [DELAY_DEPTH-2:0] sr_q, sr_d;
  logic pulse_q, pulse_d;

  // Several strobes may be in flight; each keeps its own slot
  always_comb begin
    sr_d = {sr_q[DELAY_DEPTH-3:0], strobe};
    if (delay == 5'h00) begin
      pulse_d = strobe;
    end else begin
      pulse_d = sr_q[delay - 5'h01];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sr_q <= '0;
      pulse_q <= 1'b0;
    end else begin
      sr_q <= sr_d;
      pulse_q <= pulse_d;
    end
  end

  assign pulse = pulse_q;
endmodule
`default_nettype wire

/* File: hdl/fdtp_axil_slave.sv */
// AXI4-Lite slave front end for the register file
`timescale 1ns/1ns
`default_nettype none
module fdtp_axil_slave (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire fdtp_pkg::fdtp_axil_req_t req,
  output fdtp_pkg::fdtp_axil_rsp_t rsp,
  // Register file side
  output logic wr_en,
  output logic [fdtp_pkg::IDX_W-1:0] wr_idx,
  output logic [15:0] wr_data,
  output logic [1:0] wr_be,
  input wire logic wr_hit,
  output logic [fdtp_pkg::IDX_W-1:0] rd_idx,
  input wire logic [15:0] rd_data,
  input wire logic rd_hit
);
  import fdtp_pkg::*;

  logic aw_q, aw_d, w_q, w_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [AXI_AW-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic awready, wready, arready;

  // Address and data are taken in either order, one write at a time
  assign awready = !aw_q && !bvalid_q;
  assign wready = !w_q && !bvalid_q;
  assign arready = !rvalid_q;
  assign wr_en = aw_q && w_q && !bvalid_q;
  // Index bits only; the top address bit lies outside the register map
  assign wr_idx = awaddr_q[IDX_W+1:2];
  assign wr_data = wdata_q[15:0];
  assign wr_be = wstrb_q[1:0];
  assign rd_idx = req.araddr[IDX_W+1:2];

  always_comb begin
    aw_d = aw_q;
    w_d = w_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (req.awvalid && awready) begin
      aw_d = 1'b1;
      awaddr_d = req.awaddr;
    end
    if (req.wvalid && wready) begin
      w_d = 1'b1;
      wdata_d = req.wdata;
      wstrb_d = req.wstrb;
    end
    if (wr_en) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && req.bready) begin
      bvalid_d = 1'b0;
    end
    if (req.arvalid && arready) begin
      rvalid_d = 1'b1;
      rdata_d = {16'h0000, rd_data};
      rresp_d = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && req.rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else begin
      aw_q <= aw_d;
      w_q <= w_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  always_comb begin
    rsp.awready = awready;
    rsp.wready = wready;
    rsp.bvalid = bvalid_q;
    rsp.bresp = bresp_q;
    rsp.arready = arready;
    rsp.rvalid = rvalid_q;
    rsp.rdata = rdata_q;
    rsp.rresp = rresp_q;
  end
endmodule
`default_nettype wire

/* File: hdl/fdtp_top.sv */
// Frame delimiter timestamp pulses with receive skew tracking and reporting
`timescale 1ns/1ns
`default_nettype none
module fdtp_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire fdtp_pkg::fdtp_axil_req_t axil_req,
  output fdtp_pkg::fdtp_axil_rsp_t axil_rsp,
  // PHY core, same clock
  input wire fdtp_pkg::fdtp_phy_stat_t phy_stat,
  input wire fdtp_pkg::fdtp_lane_off_t lane_offset,
  input wire logic tx_delim_strobe,
  input wire logic rx_first_sym_strobe,
  output logic soft_restart,
  // Pulse outputs
  output logic tx_frame_mark_pulse,
  output logic rx_frame_mark_pulse,
  output logic [fdtp_pkg::NUM_PINS-1:0] pulse_pin
);
  import fdtp_pkg::*;

  logic wr_en, wr_hit, rd_hit;
  logic [IDX_W-1:0] wr_idx, rd_idx;
  logic [15:0] wr_data, rd_data;
  logic [1:0] wr_be;

  fdtp_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .req(axil_req),
    .rsp(axil_rsp),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .wr_be(wr_be),
    .wr_hit(wr_hit),
    .rd_idx(rd_idx),
    .rd_data(rd_data),
    .rd_hit(rd_hit)
  );

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] data, input logic [1:0] be);
    logic [15:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = data[7:0];
    end
    if (be[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  // Register file
  logic [15:0] phy_ctl_q, phy_ctl_d;
  logic [15:0] align_ctl_q, align_ctl_d;
  logic [15:0] rx_feat_q, rx_feat_d;
  logic [15:0] pin_route_q, pin_route_d;
  logic [15:0] phase_q, phase_d;
  logic restart_q, restart_d;
  logic [15:0] skew_status;
  logic [15:0] phy_ctl_wr;

  assign phy_ctl_wr = merge(phy_ctl_q, wr_data, wr_be);

  always_comb begin
    phy_ctl_d = phy_ctl_q;
    align_ctl_d = align_ctl_q;
    rx_feat_d = rx_feat_q;
    pin_route_d = pin_route_q;
    phase_d = phase_q;
    restart_d = 1'b0;
    if (wr_en) begin
      if (wr_idx == IDX_PHY_CONTROL) begin
        phy_ctl_d = phy_ctl_wr;
        restart_d = phy_ctl_wr[SOFT_RESTART_BIT];
        phy_ctl_d[SOFT_RESTART_BIT] = 1'b0;
      end else if (wr_idx == IDX_ALIGN_CTRL) begin
        align_ctl_d = merge(align_ctl_q, wr_data, wr_be);
      end else if (wr_idx == IDX_RX_FEATURE) begin
        rx_feat_d = merge(rx_feat_q, wr_data, wr_be);
      end else if (wr_idx == IDX_PIN_ROUTE) begin
        pin_route_d = merge(pin_route_q, wr_data, wr_be);
      end else if (wr_idx == IDX_PULSE_PHASE) begin
        phase_d = merge(phase_q, wr_data, wr_be);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phy_ctl_q <= PHY_CONTROL_RST;
      align_ctl_q <= ALIGN_CTRL_RST;
      rx_feat_q <= RX_FEATURE_RST;
      pin_route_q <= PIN_ROUTE_RST;
      phase_q <= PULSE_PHASE_RST;
      restart_q <= 1'b0;
    end else begin
      phy_ctl_q <= phy_ctl_d;
      align_ctl_q <= align_ctl_d;
      rx_feat_q <= rx_feat_d;
      pin_route_q <= pin_route_d;
      phase_q <= phase_d;
      restart_q <= restart_d;
    end
  end

  assign soft_restart = restart_q;

  // Writes to the read-only status are accepted and dropped
  always_comb begin
    wr_hit = (wr_idx == IDX_PHY_CONTROL) || (wr_idx == IDX_SKEW_STATUS) || (wr_idx == IDX_ALIGN_CTRL)
      || (wr_idx == IDX_RX_FEATURE) || (wr_idx == IDX_PIN_ROUTE) || (wr_idx == IDX_PULSE_PHASE);
  end

  always_comb begin
    rd_hit = 1'b1;
    if (rd_idx == IDX_PHY_CONTROL) begin
      rd_data = phy_ctl_q;
    end else if (rd_idx == IDX_SKEW_STATUS) begin
      rd_data = skew_status;
    end else if (rd_idx == IDX_ALIGN_CTRL) begin
      rd_data = align_ctl_q;
    end else if (rd_idx == IDX_RX_FEATURE) begin
      rd_data = rx_feat_q;
    end else if (rd_idx == IDX_PIN_ROUTE) begin
      rd_data = pin_route_q;
    end else if (rd_idx == IDX_PULSE_PHASE) begin
      rd_data = phase_q;
    end else begin
      rd_data = 16'h0000;
      rd_hit = 1'b0;
    end
  end

  // Link tracking and skew capture
  logic link_q, link_d;
  logic gig_q, gig_d;
  logic master_q, master_d;
  logic valid_q, valid_d;
  logic [3:0] skew_q, skew_d;
  logic [5:0] lane_max, lane_min, spread;
  logic [3:0] spread_lim;

  always_comb begin
    lane_max = lane_offset[0];
    lane_min = lane_offset[0];
    for (int i = 1; i < 4; i++) begin
      if (lane_offset[i] > lane_max) begin
        lane_max = lane_offset[i];
      end
      if (lane_offset[i] < lane_min) begin
        lane_min = lane_offset[i];
      end
    end
    spread = lane_max - lane_min;
    if (spread > {2'b00, SKEW_LIMIT}) begin
      spread_lim = SKEW_LIMIT;
    end else begin
      spread_lim = spread[3:0];
    end
  end

  always_comb begin
    link_d = phy_stat.link_up;
    gig_d = gig_q;
    master_d = master_q;
    valid_d = valid_q;
    skew_d = skew_q;
    if (!phy_stat.link_up) begin
      valid_d = 1'b0;
      skew_d = 4'h0;
    end else if (!link_q) begin
      gig_d = phy_stat.speed_1000;
      master_d = phy_stat.master;
      skew_d = phy_stat.speed_1000 ? spread_lim : 4'h0;
      // Init value must precede the link
      valid_d = phy_stat.speed_1000 && (align_ctl_q == ALIGN_INIT_VALUE);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_q <= 1'b0;
      gig_q <= 1'b0;
      master_q <= 1'b0;
      valid_q <= 1'b0;
      skew_q <= 4'h0;
    end else begin
      link_q <= link_d;
      gig_q <= gig_d;
      master_q <= master_d;
      valid_q <= valid_d;
      skew_q <= skew_d;
    end
  end

  // Skew status: only one field is live, chosen by the link role
  always_comb begin
    skew_status = 16'h0000;
    if (valid_q && gig_q) begin
      if (master_q) begin
        skew_status[MASTER_SKEW_LSB +: 4] = skew_q;
      end else begin
        skew_status[SLAVE_SKEW_LSB +: 4] = skew_q;
      end
    end
  end

  // Pulse generation
  logic mac_extras_enable;
  logic tx_dly_pulse, rx_dly_pulse;
  logic [4:0] tx_delay, rx_delay;
  logic [3:0] tx_phase, rx_phase;

  assign mac_extras_enable = rx_feat_q[MAC_EXTRAS_BIT];
  assign tx_phase = phase_q[TX_PHASE_LSB +: 4];
  assign rx_phase = phase_q[RX_PHASE_LSB +: 4];

  assign tx_delay = 5'(int'(tx_phase) * STEP_CYCLES);
  // Receive adds the held alignment delay
  assign rx_delay = 5'((int'(rx_phase) + int'(skew_q)) * STEP_CYCLES);

  fdtp_pulse_delay u_tx_dly (
    .aclk(aclk),
    .aresetn(aresetn),
    .strobe(tx_delim_strobe),
    .delay(tx_delay),
    .pulse(tx_dly_pulse)
  );

  fdtp_pulse_delay u_rx_dly (
    .aclk(aclk),
    .aresetn(aresetn),
    .strobe(rx_first_sym_strobe),
    .delay(rx_delay),
    .pulse(rx_dly_pulse)
  );

  logic tx_out_q, tx_out_d, rx_out_q, rx_out_d;
  logic [NUM_PINS-1:0] pin_q, pin_d;
  logic [SEL_W-1:0] tx_sel, rx_sel;

  assign tx_sel = pin_route_q[TX_SEL_LSB +: SEL_W];
  assign rx_sel = pin_route_q[RX_SEL_LSB +: SEL_W];

  // Gating at the output also drops pulses already in the delay line
  always_comb begin
    tx_out_d = mac_extras_enable && tx_dly_pulse;
    rx_out_d = mac_extras_enable && rx_dly_pulse;
    for (int p = 0; p < NUM_PINS; p++) begin
      pin_d[p] = (tx_out_d && pin_route_q[TX_ROUTE_EN_BIT] && (tx_sel == SEL_W'(p)))
        || (rx_out_d && pin_route_q[RX_ROUTE_EN_BIT] && (rx_sel == SEL_W'(p)));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_out_q <= 1'b0;
      rx_out_q <= 1'b0;
      pin_q <= '0;
    end else begin
      tx_out_q <= tx_out_d;
      rx_out_q <= rx_out_d;
      pin_q <= pin_d;
    end
  end

  assign tx_frame_mark_pulse = tx_out_q;
  assign rx_frame_mark_pulse = rx_out_q;
  assign pulse_pin = pin_q;
endmodule
`default_nettype wire

/* File: test/fdtp_mac_model.sv */
// Timestamp unit model that stamps strobes and frame mark pulses
`timescale 1ns/1ns
`default_nettype none
module fdtp_mac_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Strobes of the PHY core and pulses of the block
  input wire logic tx_strobe,
  input wire logic rx_strobe,
  input wire logic tx_pulse,
  input wire logic rx_pulse,
  input wire logic [3:0] pins,
  // Measurements
  output var int tx_lat,
  output var int rx_lat,
  output var int tx_cnt,
  output var int rx_cnt,
  output var logic [3:0] tx_pin,
  output var logic [3:0] rx_pin
);
  int now = 0;
  int tx_s = 0;
  int rx_s = 0;
  initial begin
    tx_lat = 0;
    rx_lat = 0;
    tx_pin = 4'h0;
    rx_pin = 4'h0;
  end
  always @(posedge aclk) begin
    now <= now + 1;
    if (tx_strobe) tx_s <= now;
    if (rx_strobe) rx_s <= now;
    if (!aresetn) begin
      tx_cnt <= 0;
      rx_cnt <= 0;
    end
    if (tx_pulse === 1'b1) begin
      tx_lat <= now - tx_s;
      tx_pin <= pins;
      tx_cnt <= tx_cnt + 1;
    end
    if (rx_pulse === 1'b1) begin
      rx_lat <= now - rx_s;
      rx_pin <= pins;
      rx_cnt <= rx_cnt + 1;
    end
  end
endmodule
`default_nettype wire

/* File: test/fdtp_monitor.sv */
// Assertion checker for the frame delimiter timestamp pulse block
`timescale 1ns/1ns
`default_nettype none
module fdtp_monitor (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire fdtp_pkg::fdtp_axil_req_t axil_req,
  input wire fdtp_pkg::fdtp_axil_rsp_t axil_rsp,
  // PHY core
  input wire fdtp_pkg::fdtp_phy_stat_t phy_stat,
  input wire fdtp_pkg::fdtp_lane_off_t lane_offset,
  input wire logic tx_delim_strobe,
  input wire logic rx_first_sym_strobe,
  input wire logic soft_restart,
  // Pulses
  input wire logic tx_frame_mark_pulse,
  input wire logic rx_frame_mark_pulse,
  input wire logic [fdtp_pkg::NUM_PINS-1:0] pulse_pin
);
  import fdtp_pkg::*;
  // Cycles since the last strobe, saturating so old strobes never excuse a pulse
  logic [5:0] tx_age_q, tx_age_d, rx_age_q, rx_age_d;
  always_comb begin
    tx_age_d = tx_delim_strobe ? 6'h00 : tx_age_q + {5'h00, tx_age_q != 6'h3F};
    rx_age_d = rx_first_sym_strobe ? 6'h00 : rx_age_q + {5'h00, rx_age_q != 6'h3F};
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_age_q <= 6'h3F;
      rx_age_q <= 6'h3F;
    end else begin
      tx_age_q <= tx_age_d;
      rx_age_q <= rx_age_d;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready;
  endsequence
  sequence s_rd_taken;
    axil_req.arvalid && axil_rsp.arready;
  endsequence
  a_tx_pulse_cause: assert property (tx_frame_mark_pulse |-> tx_age_q <= 6'd16)
    else $error("tx mark pulse without recent strobe");
  a_rx_pulse_cause: assert property (rx_frame_mark_pulse |-> rx_age_q <= 6'd31)
    else $error("rx mark pulse without recent strobe");
  a_pin_follows_mark: assert property (|pulse_pin |-> tx_frame_mark_pulse || rx_frame_mark_pulse)
    else $error("pin pulse without mark pulse");
  a_pin_count_bound: assert property ($countones(pulse_pin) <= 2)
    else $error("more pins active than pulses");
  a_restart_with_resp: assert property (soft_restart |-> axil_rsp.bvalid)
    else $error("soft restart outside write response");
  a_restart_single: assert property (soft_restart |=> !soft_restart)
    else $error("soft restart longer than one cycle");
  a_write_answer: assert property (s_wr_taken |-> ##1 !axil_rsp.bvalid ##1 axil_rsp.bvalid)
    else $error("write response not two cycles after take");
  a_write_refused: assert property (axil_rsp.bvalid |-> !axil_rsp.awready && !axil_rsp.wready)
    else $error("write taken while response pending");
  a_read_answer: assert property (s_rd_taken |=> axil_rsp.rvalid)
    else $error("read data not one cycle after take");
  a_read_retire: assert property (axil_rsp.rvalid && axil_req.rready |=> !axil_rsp.rvalid)
    else $error("read data held after retire");
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !tx_frame_mark_pulse
    && !rx_frame_mark_pulse && pulse_pin == '0 && !soft_restart)
    else $error("outputs active after reset edge");
endmodule
bind fdtp_top fdtp_monitor fdtp_monitor_inst (.aclk(aclk), .aresetn(aresetn), .axil_req(axil_req),
  .axil_rsp(axil_rsp), .phy_stat(phy_stat), .lane_offset(lane_offset), .tx_delim_strobe(tx_delim_strobe),
  .rx_first_sym_strobe(rx_first_sym_strobe), .soft_restart(soft_restart),
  .tx_frame_mark_pulse(tx_frame_mark_pulse), .rx_frame_mark_pulse(rx_frame_mark_pulse), .pulse_pin(pulse_pin));
`default_nettype wire

/* File: test/fdtp_top_tb.sv */
// Self-checking bench for the frame delimiter timestamp pulse block
`timescale 1ns/1ns
`default_nettype none
module fdtp_top_tb;
  import fdtp_pkg::*;
  logic aclk, aresetn, tx_stb, rx_stb, restart, tx_mark, rx_mark;
  fdtp_axil_req_t req;
  fdtp_axil_rsp_t rsp;
  fdtp_phy_stat_t stat;
  fdtp_lane_off_t lanes;
  logic [NUM_PINS-1:0] pins;
  logic [3:0] tx_pin, rx_pin;
  logic [31:0] rd;
  logic [1:0] rs;
  int tx_lat, rx_lat, tx_cnt, rx_cnt;
  int bad_count = 0;
  int cmp_count = 0;
  int sr_cnt = 0;
  logic [11:0] reg_a [6] = '{12'h07C, 12'h154, 12'h3A4, 12'h4D0, 12'h780, 12'h784};
  fdtp_top fdtp_top_inst (.aclk(aclk), .aresetn(aresetn), .axil_req(req), .axil_rsp(rsp), .phy_stat(stat),
    .lane_offset(lanes), .tx_delim_strobe(tx_stb), .rx_first_sym_strobe(rx_stb), .soft_restart(restart),
    .tx_frame_mark_pulse(tx_mark), .rx_frame_mark_pulse(rx_mark), .pulse_pin(pins));
  fdtp_mac_model fdtp_mac_model_inst (.aclk(aclk), .aresetn(aresetn), .tx_strobe(tx_stb), .rx_strobe(rx_stb),
    .tx_pulse(tx_mark), .rx_pulse(rx_mark), .pins(pins), .tx_lat(tx_lat), .rx_lat(rx_lat), .tx_cnt(tx_cnt),
    .rx_cnt(rx_cnt), .tx_pin(tx_pin), .rx_pin(rx_pin));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) if (restart === 1'b1) sr_cnt++;
  // Wide enough for a response code beside the read data
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("Compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Address and data are offered together; each is released when taken
  task automatic wr(input logic [11:0] a, input logic [15:0] d, output logic [1:0] r);
    logic aw, w, ta, tw, hit;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= {16'h0000, d};
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w) begin
      @(negedge aclk);
      ta = aw && rsp.awready;
      tw = w && rsp.wready;
      @(posedge aclk);
      if (ta) req.awvalid <= 1'b0;
      if (tw) req.wvalid <= 1'b0;
      aw = aw && !ta;
      w = w && !tw;
    end
    do begin
      @(negedge aclk);
      hit = rsp.bvalid;
      r = rsp.bresp;
      @(posedge aclk);
    end while (!hit);
    req.bready <= 1'b0;
  endtask
  task automatic rdr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic hit;
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(negedge aclk);
      hit = rsp.arready;
      @(posedge aclk);
    end while (!hit);
    req.arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      hit = rsp.rvalid;
      d = rsp.rdata;
      r = rsp.rresp;
      @(posedge aclk);
    end while (!hit);
    req.rready <= 1'b0;
  endtask
  // Settling wait covers the longest delay of phase plus clamped skew
  task automatic fire(input logic is_rx, input int lat, input logic [3:0] pin);
    int c;
    c = is_rx ? rx_cnt : tx_cnt;
    @(posedge aclk);
    if (is_rx) rx_stb <= 1'b1;
    else tx_stb <= 1'b1;
    @(posedge aclk);
    rx_stb <= 1'b0;
    tx_stb <= 1'b0;
    repeat (40) @(posedge aclk);
    check(is_rx ? rx_cnt : tx_cnt, lat < 0 ? c : c + 1);
    if (lat >= 0) begin
      check(is_rx ? rx_lat : tx_lat, lat);
      check(is_rx ? rx_pin : tx_pin, pin);
    end
  endtask
  task automatic link(input logic [2:0] s, input fdtp_lane_off_t off, input logic [31:0] st);
    @(posedge aclk);
    stat <= s;
    lanes <= off;
    repeat (4) @(posedge aclk);
    rdr(12'h154, rd, rs);
    check(rd, st);
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    test_done();
  end
  initial begin
    aresetn = 1'b0;
    req = '0;
    stat = '0;
    lanes = '0;
    tx_stb = 1'b0;
    rx_stb = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (reg_a[i]) begin
      rdr(reg_a[i], rd, rs);
      check({rs, rd}, {RESP_OKAY, 32'h0000_0000});
    end
    rdr(12'h008, rd, rs);
    check({rs, rd}, {RESP_SLVERR, 32'h0000_0000});
    fire(1'b0, -1, 4'h0);
    wr(12'h4D0, 16'h0080, rs);
    wr(12'h780, 16'h00A9, rs);
    for (int t = 0; t <= 15; t += 5) begin
      wr(12'h784, {4'h0, t[3:0], 8'h02}, rs);
      fire(1'b0, 2 + t, 4'h4);
    end
    fire(1'b1, 4, 4'h2);
    wr(12'h3A4, ALIGN_INIT_VALUE, rs);
    link(3'b111, {6'd7, 6'd5, 6'd10, 6'd3}, 32'h0000_0070);
    fire(1'b1, 11, 4'h2);
    link(3'b111, '0, 32'h0000_0070);
    link(3'b000, '0, 32'h0000_0000);
    link(3'b110, {6'd0, 6'd40, 6'd2, 6'd3}, 32'h0000_000F);
    fire(1'b1, 19, 4'h2);
    wr(12'h154, 16'hFFFF, rs);
    check(rs, RESP_OKAY);
    link(3'b110, '0, 32'h0000_000F);
    link(3'b000, {4{6'd9}}, 32'h0000_0000);
    link(3'b110, {4{6'd9}}, 32'h0000_0000);
    fire(1'b1, 4, 4'h2);
    link(3'b000, {6'd7, 6'd5, 6'd10, 6'd3}, 32'h0000_0000);
    link(3'b100, {6'd7, 6'd5, 6'd10, 6'd3}, 32'h0000_0000);
    fire(1'b1, 4, 4'h2);
    // Gigabit link formed without the init value reports no skew
    wr(12'h3A4, 16'h0000, rs);
    link(3'b000, '0, 32'h0000_0000);
    link(3'b111, {6'd7, 6'd5, 6'd10, 6'd3}, 32'h0000_0000);
    wr(12'h07C, 16'h4000, rs);
    rdr(12'h07C, rd, rs);
    check(rd, 32'h0000_0000);
    check(sr_cnt, 1);
    wr(12'h780, 16'h0008, rs);
    fire(1'b0, 17, 4'h0);
    wr(12'h4D0, 16'h0000, rs);
    fire(1'b1, -1, 4'h0);
    // Mid-run reset drops the held link state and the init value
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(12'h154, rd, rs);
    check({rs, rd}, {RESP_OKAY, 32'h0000_0000});
    rdr(12'h3A4, rd, rs);
    check({rs, rd}, {RESP_OKAY, 32'h0000_0000});
    test_done();
  end
endmodule
`default_nettype wire
